// ===== logic/rse_pkg.sv
// package: constants and types for the ram/io/timer select and edge interrupt block
`default_nettype none
package rse_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned ADDR_W     = 7;
   localparam int unsigned RAM_DEPTH  = 128;
   // ------------------------------------------------------------
   // address bit positions
   // ------------------------------------------------------------
   localparam int unsigned A0_BIT     = 0;
   localparam int unsigned A1_BIT     = 1;
   localparam int unsigned A2_BIT     = 2;
   localparam int unsigned A3_BIT     = 3;
   localparam int unsigned A4_BIT     = 4;
   // ------------------------------------------------------------
   // port register select codes on a1:a0
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_PA_OUT  = 2'h0;
   localparam logic [1:0] SEL_PA_DIR  = 2'h1;
   localparam logic [1:0] SEL_PB_OUT  = 2'h2;
   localparam logic [1:0] SEL_PB_DIR  = 2'h3;
   // ------------------------------------------------------------
   // pending flag bit positions
   // ------------------------------------------------------------
   localparam int unsigned FLAG_TIMER_BIT = 7;
   localparam int unsigned FLAG_EDGE_BIT  = 6;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] REG_RST     = 8'h00;
   localparam logic [1:0] PRESC_RST   = 2'h0;

   // prescale choices on a1:a0
   typedef enum logic [1:0] {
      RSE_DIV_1    = 2'b00,
      RSE_DIV_8    = 2'b01,
      RSE_DIV_64   = 2'b10,
      RSE_DIV_1024 = 2'b11
   } rse_presc_e;

   // bus request from the processor
   typedef struct packed {
      logic        sel;        // chip selected
      logic        ram_vs_io_select_n; // high: io/timer, low: ram
      logic        rd;         // high read, low write
      logic [6:0]  addr;       // a6..a0
      logic [7:0]  wdata;      // write data
   } rse_req_s;

   // block state apart from the ram words
   typedef struct packed {
      logic [7:0]  pa_out;     // port_a_output
      logic [7:0]  pa_dir;     // port_a_direction
      logic [7:0]  pb_out;     // port_b_output
      logic [7:0]  pb_dir;     // port_b_direction
      logic [7:0]  count;      // interval_count holding value
      rse_presc_e  presc;      // chosen prescale
      logic        tmr_en;     // timer irq gate
      logic        edge_en;    // edge irq gate
      logic        edge_pos;   // high: positive edge
      logic        tmr_flag;   // timer pending
      logic        edge_flag;  // edge pending
      logic        pin_s1;     // sync stage 1
      logic        pin_s2;     // sync stage 2
      logic        pin_old;    // previous synced level
      logic        load_stb;   // timer load pulse
      logic [7:0]  rdata;      // read data
      logic        irq_n;      // interrupt request, active low
   } rse_state_s;
endpackage : rse_pkg
`default_nettype wire

// ===== logic/rse_core.sv
// module: address decode, port registers, ram and edge interrupt
`timescale 1ns/1ps
`default_nettype none

module rse_core (
   // clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_i,
   // processor bus, one cycle access strobe
   input  wire rse_pkg::rse_req_s     req_i,
   input  wire logic                  strobe_i,
   output logic [7:0]                 rdata_o,
   // edge sense pin level
   input  wire logic                  edge_sense_pin_i,
   // timer side: timeout event and live count
   input  wire logic                  tmr_timeout_i,
   input  wire logic [7:0]            tmr_count_i,
   // register contents toward the port and timer logic
   output logic [7:0]                 pa_out_o,
   output logic [7:0]                 pa_dir_o,
   output logic [7:0]                 pb_out_o,
   output logic [7:0]                 pb_dir_o,
   output logic [7:0]                 tmr_load_o,
   output rse_pkg::rse_presc_e        tmr_presc_o,
   output logic                       tmr_load_stb_o,
   // interrupt request, active low
   output logic                       irq_n_o
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // true when the access hits the port/timer section with a2 given
   function automatic logic io_hit(input rse_pkg::rse_req_s r, input logic a2);
      io_hit = r.sel && r.ram_vs_io_select_n && (r.addr[rse_pkg::A2_BIT] == a2);
   endfunction : io_hit

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // ram words live outside the state struct; every other bit is in st_q
   logic [7:0]          ram_q [rse_pkg::RAM_DEPTH];  // scratch ram
   rse_pkg::rse_state_s st_q;                        // registered state
   rse_pkg::rse_state_s st_d;                        // next state

   // ------------------------------------------------------------
   // ram, no reset on the array
   // ------------------------------------------------------------
   // select line low writes the ram
   // no reset on the array, so a read before any write returns junk
   always_ff @(posedge clk_sys_i) begin
      if (strobe_i && req_i.sel && !req_i.ram_vs_io_select_n && !req_i.rd) begin
         ram_q[req_i.addr] <= req_i.wdata;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic edge_seen;   // active transition detected
      logic wr;          // bus write this cycle
      logic rd;          // bus read this cycle
      edge_seen  = 1'b0;
      wr         = strobe_i && !req_i.rd;
      rd         = strobe_i && req_i.rd;
      st_d       = st_q;
      st_d.load_stb = 1'b0;   // pulse lasts one cycle
      // pin synchroniser, stage 1 read only by stage 2
      st_d.pin_s1  = edge_sense_pin_i;
      st_d.pin_s2  = st_q.pin_s1;
      st_d.pin_old = st_q.pin_s2;
      if (st_q.edge_pos) begin
         edge_seen = st_q.pin_s2 && !st_q.pin_old;
      end else begin
         edge_seen = !st_q.pin_s2 && st_q.pin_old;
      end
      st_d.rdata = st_q.rdata;
      // ram read, word registered with the rest of the read data
      if (rd && req_i.sel && !req_i.ram_vs_io_select_n) begin
         st_d.rdata = ram_q[req_i.addr];
      end
      if (io_hit(req_i, 1'b0) && (wr || rd)) begin
         case (req_i.addr[rse_pkg::A1_BIT:rse_pkg::A0_BIT])
            rse_pkg::SEL_PA_OUT: begin
               if (wr) st_d.pa_out = req_i.wdata;
               st_d.rdata = st_q.pa_out;
            end
            rse_pkg::SEL_PA_DIR: begin
               if (wr) st_d.pa_dir = req_i.wdata;
               st_d.rdata = st_q.pa_dir;
            end
            rse_pkg::SEL_PB_OUT: begin
               if (wr) st_d.pb_out = req_i.wdata;
               st_d.rdata = st_q.pb_out;
            end
            rse_pkg::SEL_PB_DIR: begin
               if (wr) st_d.pb_dir = req_i.wdata;
               st_d.rdata = st_q.pb_dir;
            end
            default: begin
               st_d.rdata = rse_pkg::REG_RST;
            end
         endcase
      end
      // a2 high selects timer, edge control and flags
      if (io_hit(req_i, 1'b1)) begin
         if (wr && req_i.addr[rse_pkg::A4_BIT]) begin
            st_d.presc = rse_pkg::rse_presc_e'(req_i.addr[rse_pkg::A1_BIT:rse_pkg::A0_BIT]);
            st_d.count = req_i.wdata;
            st_d.load_stb = 1'b1;
            st_d.tmr_en = req_i.addr[rse_pkg::A3_BIT];
            st_d.tmr_flag = 1'b0;
         end else if (wr) begin
            st_d.edge_en  = req_i.addr[rse_pkg::A1_BIT];
            st_d.edge_pos = req_i.addr[rse_pkg::A0_BIT];
         end else if (rd && !req_i.addr[rse_pkg::A0_BIT]) begin
            st_d.rdata  = tmr_count_i;
            // a3 sets timer gate on read
            st_d.tmr_en = req_i.addr[rse_pkg::A3_BIT];
            st_d.tmr_flag = 1'b0;
         end else if (rd) begin
            st_d.rdata = rse_pkg::REG_RST;
            st_d.rdata[rse_pkg::FLAG_TIMER_BIT] = st_q.tmr_flag;
            st_d.rdata[rse_pkg::FLAG_EDGE_BIT]  = st_q.edge_flag;
            // this read clears a stale edge flag
            st_d.edge_flag = 1'b0;
         end
      end
      // timeout beats a clear in the same cycle
      if (tmr_timeout_i) begin
         st_d.tmr_flag = 1'b1;
      end
      // edge sets flag, wins over clear
      if (edge_seen) begin
         st_d.edge_flag = 1'b1;
      end
      st_d.irq_n = !((st_d.edge_flag && st_d.edge_en) || (st_d.tmr_flag && st_d.tmr_en));
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q.pa_out    <= rse_pkg::REG_RST;
         st_q.pa_dir    <= rse_pkg::REG_RST;
         st_q.pb_out    <= rse_pkg::REG_RST;
         st_q.pb_dir    <= rse_pkg::REG_RST;
         st_q.count     <= rse_pkg::REG_RST;
         st_q.presc     <= rse_pkg::RSE_DIV_1;
         st_q.tmr_en    <= 1'b0;
         st_q.edge_en   <= 1'b0;
         st_q.edge_pos  <= 1'b0;
         st_q.tmr_flag  <= 1'b0;
         // the allowed in-reset edge set is not taken
         st_q.edge_flag <= 1'b0;
         // sync stages start low so a pin held low through reset
         // shows no falling edge on release; a pin held high shows
         // a rising edge, ignored in the negative-edge reset mode
         st_q.pin_s1    <= 1'b0;
         st_q.pin_s2    <= 1'b0;
         st_q.pin_old   <= 1'b0;
         st_q.rdata     <= rse_pkg::REG_RST;
         st_q.irq_n     <= 1'b1;
         st_q.load_stb  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // every output is a field of the state register
   assign rdata_o        = st_q.rdata;
   assign pa_out_o       = st_q.pa_out;
   assign pa_dir_o       = st_q.pa_dir;
   assign pb_out_o       = st_q.pb_out;
   assign pb_dir_o       = st_q.pb_dir;
   assign tmr_load_o     = st_q.count;
   assign tmr_presc_o    = st_q.presc;
   assign tmr_load_stb_o = st_q.load_stb;
   assign irq_n_o        = st_q.irq_n;

endmodule : rse_core

`default_nettype wire

// ===== tb/rse_core_assertions.sv
// checker: port properties of the select and edge interrupt core
`timescale 1ns/1ps
`default_nettype none
module rse_core_chk (
   // clock and reset
   input wire logic                clk_sys_i,
   input wire logic                rst_i,
   // processor bus
   input wire rse_pkg::rse_req_s   req_i,
   input wire logic                strobe_i,
   input wire logic [7:0]          rdata_o,
   // pin and timer side
   input wire logic                edge_sense_pin_i,
   input wire logic                tmr_timeout_i,
   input wire logic [7:0]          tmr_count_i,
   // register outputs
   input wire logic [7:0]          pa_out_o,
   input wire logic [7:0]          pa_dir_o,
   input wire logic [7:0]          pb_out_o,
   input wire logic [7:0]          pb_dir_o,
   input wire logic [7:0]          tmr_load_o,
   input wire rse_pkg::rse_presc_e tmr_presc_o,
   input wire logic                tmr_load_stb_o,
   input wire logic                irq_n_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // decoded io accesses
   wire io = strobe_i && req_i.sel && req_i.ram_vs_io_select_n;
   wire pw = io && !req_i.rd && !req_i.addr[2];
   wire tw = io && !req_i.rd && req_i.addr[2] && req_i.addr[4];
   wire ew = io && !req_i.rd && req_i.addr[2] && !req_i.addr[4];
   port_a_load_a: assert property (pw && req_i.addr[1:0] == 2'h0 |=> pa_out_o == $past(req_i.wdata))
      else $error("port a output not loaded");
   port_b_dir_a: assert property (pw && req_i.addr[1:0] == 2'h3 |=> pb_dir_o == $past(req_i.wdata))
      else $error("port b direction not loaded");
   timer_write_a: assert property (tw |=> tmr_load_stb_o && tmr_presc_o == $past(req_i.addr[1:0]))
      else $error("timer write not taken");
   load_cause_a: assert property (tmr_load_stb_o |-> $past(tw) && tmr_load_o == $past(req_i.wdata))
      else $error("timer load without write");
   count_read_a: assert property (io && req_i.rd && req_i.addr[2] && !req_i.addr[0]
      |=> rdata_o == $past(tmr_count_i))
      else $error("timer count not returned");
   edge_ctl_a: assert property (ew |=> !tmr_load_stb_o && $stable(tmr_presc_o))
      else $error("edge control touched timer");
   ram_apart_a: assert property (strobe_i && req_i.sel && !req_i.ram_vs_io_select_n
      |=> $stable(pa_out_o) && $stable(pb_dir_o))
      else $error("ram access changed port");
   reset_quiet_a: assert property ($fell(rst_i) |-> irq_n_o)
      else $error("irq asserted after reset");
   cover property (tw);
   cover property (ew ##[1:20] $fell(irq_n_o));
   cover property (io && req_i.rd && req_i.addr[2] && req_i.addr[0]);
endmodule : rse_core_chk
`default_nettype wire

// ===== tb/rse_cpu_model.sv
// partner: processor issuing one-cycle bus accesses
`timescale 1ns/1ps
`default_nettype none
module rse_cpu_model (
   // clock
   input  wire logic            clk_sys_i,
   // bus toward the core
   output var rse_pkg::rse_req_s req_o,
   output var logic             strobe_o,
   input  wire logic [7:0]      rdata_i
);
   initial begin
      req_o    = '0;
      strobe_o = 1'b0;
   end
   // whole access, data on the bus released after the taking edge
   task automatic acc(input logic io_sel, input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
      @(posedge clk_sys_i);
      #1;
      req_o    = '{sel: 1'b1, ram_vs_io_select_n: io_sel, rd: rd, addr: a, wdata: wd};
      strobe_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      strobe_o    = 1'b0;
      req_o.sel   = 1'b0;
      req_o.wdata = ~wd;
      q           = rdata_i;
   endtask : acc
   task automatic flush();
      logic [7:0] q;
      acc(1'b1, 1'b1, 7'h05, 8'h00, q);
   endtask : flush
endmodule : rse_cpu_model
`default_nettype wire

// ===== tb/riot_select_and_edge_irq_tb_top.sv
// testbench: scenarios for the select and edge interrupt core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("Error %0t %h %h", $time, (a), (b)); end end
module riot_select_and_edge_irq_tb_top;
   logic                clk_sys_i = 1'b0;
   logic                rst_i = 1'b1;
   logic                edge_sense_pin_i = 1'b0;
   logic                tmr_timeout_i = 1'b0;
   logic [7:0]          tmr_count_i = 8'h3c;
   rse_pkg::rse_req_s   req_i;
   logic                strobe_i, tmr_load_stb_o, irq_n_o;
   logic [7:0]          rdata_o, pa_out_o, pa_dir_o, pb_out_o, pb_dir_o, tmr_load_o, q;
   rse_pkg::rse_presc_e tmr_presc_o;
   int                  n_errors = 0;
   int                  checks = 0;
   rse_core DUT (.clk_sys_i, .rst_i, .req_i, .strobe_i, .rdata_o, .edge_sense_pin_i, .tmr_timeout_i,
      .tmr_count_i, .pa_out_o, .pa_dir_o, .pb_out_o, .pb_dir_o, .tmr_load_o, .tmr_presc_o, .tmr_load_stb_o, .irq_n_o);
   rse_cpu_model cpu (.clk_sys_i, .req_o(req_i), .strobe_o(strobe_i), .rdata_i(rdata_o));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask : tick
   // bounded wait for the irq level, then judge it
   task automatic wirq(input logic v, input int n);
      repeat (n) if (irq_n_o !== v) tick();
      `CHK(irq_n_o, v)
   endtask : wirq
   task automatic quiet();
      repeat (8) tick();
      `CHK(irq_n_o, 1'b1)
   endtask : quiet
   task automatic t_ports();
      for (int i = 0; i < 4; i++) cpu.acc(1'b1, 1'b0, 7'(i), 8'h81 + 8'(i * 17), q);
      `CHK({pa_out_o, pa_dir_o, pb_out_o, pb_dir_o}, 32'h8192a3b4)
      for (int i = 0; i < 4; i++) begin
         cpu.acc(1'b1, 1'b1, 7'h70 | 7'(i), 8'h00, q);
         `CHK(q, 8'h81 + 8'(i * 17))
      end
   endtask : t_ports
   task automatic t_ram();
      cpu.acc(1'b0, 1'b0, 7'h00, 8'h5a, q);
      cpu.acc(1'b0, 1'b0, 7'h7f, 8'hc3, q);
      `CHK(pa_out_o, 8'h81)
      cpu.acc(1'b0, 1'b1, 7'h00, 8'h00, q);
      `CHK(q, 8'h5a)
      cpu.acc(1'b0, 1'b1, 7'h7f, 8'h00, q);
      `CHK(q, 8'hc3)
   endtask : t_ram
   task automatic pulse();
      tick();
      tmr_timeout_i = 1'b1;
      tick();
      tmr_timeout_i = 1'b0;
   endtask : pulse
   task automatic t_timer();
      for (int p = 0; p < 4; p++) begin
         cpu.acc(1'b1, 1'b0, 7'h14 | 7'(p), 8'h40 + 8'(p), q);
         `CHK({tmr_load_stb_o, tmr_presc_o, tmr_load_o}, {1'b1, 2'(p), 8'h40 + 8'(p)})
      end
      cpu.acc(1'b1, 1'b0, 7'h1c, 8'h10, q);
      pulse();
      wirq(1'b0, 8);
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      `CHK({q[7], irq_n_o}, 2'b10)
      tmr_count_i = 8'h96;
      cpu.acc(1'b1, 1'b1, 7'h04, 8'h00, q);
      `CHK(q, 8'h96)
      wirq(1'b1, 4);
      pulse();
      quiet();
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      `CHK(q[7], 1'b1)
      cpu.acc(1'b1, 1'b0, 7'h1c, 8'h10, q);
      quiet();
   endtask : t_timer
   task automatic t_edge();
      cpu.acc(1'b1, 1'b0, 7'h07, 8'h00, q);
      tick();
      edge_sense_pin_i = 1'b1;
      wirq(1'b0, 8);
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      `CHK(q[6], 1'b1)
      wirq(1'b1, 3);
      edge_sense_pin_i = 1'b0;
      quiet();
      cpu.acc(1'b1, 1'b0, 7'h06, 8'hff, q);
      edge_sense_pin_i = 1'b1;
      quiet();
      edge_sense_pin_i = 1'b0;
      wirq(1'b0, 8);
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      cpu.acc(1'b1, 1'b0, 7'h05, 8'h00, q);
      edge_sense_pin_i = 1'b1;
      quiet();
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      `CHK(q[6], 1'b1)
   endtask : t_edge
   task automatic t_reset();
      cpu.acc(1'b1, 1'b0, 7'h07, 8'h00, q);
      rst_i = 1'b1;
      repeat (3) tick();
      edge_sense_pin_i = 1'b0;
      rst_i = 1'b0;
      `CHK({pa_out_o, tmr_presc_o}, {rse_pkg::REG_RST, rse_pkg::PRESC_RST})
      cpu.flush();
      edge_sense_pin_i = 1'b1;
      quiet();
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      `CHK(q[6], 1'b0)
      edge_sense_pin_i = 1'b0;
      quiet();
      cpu.acc(1'b1, 1'b1, 7'h05, 8'h00, q);
      `CHK(q[6], 1'b1)
   endtask : t_reset
   task automatic results();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   initial begin
      repeat (3) tick();
      rst_i = 1'b0;
      cpu.flush();
      t_ports();
      t_ram();
      t_timer();
      t_edge();
      t_reset();
      results();
   end
   // watchdog well past the expected run
   initial begin
      #50000;
      n_errors++;
      results();
   end
endmodule : riot_select_and_edge_irq_tb_top
bind rse_core rse_core_chk u_chk (.clk_sys_i, .rst_i, .req_i, .strobe_i, .rdata_o, .edge_sense_pin_i,
   .tmr_timeout_i, .tmr_count_i, .pa_out_o, .pa_dir_o, .pb_out_o, .pb_dir_o, .tmr_load_o, .tmr_presc_o,
   .tmr_load_stb_o, .irq_n_o);
`default_nettype wire
